// ---- inc/io_space_pkg.sv ----
// Overview of operation
// - register space of 512 bytes, apart from program and data memory, decoded from accesses.
// - two equal banks; one 8-bit offset reaches different registers per bank.
// - bank-select flag bit set sends every access except the flag register at f7 to bank 1, the configuration bank.
// - mixed-access registers apply read, write and clear behaviour bit by bit.
// - active-high external reset pin resets the device, register contents included.
package io_space_pkg;

  // ****************************************************************
  // bus carriers
  // ****************************************************************
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [DAT_W-1:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
  } wb_rsp_type;

  // ****************************************************************
  // space layout
  // ****************************************************************
  localparam int SPACE_BYTES = 512;
  localparam int BANK_BYTES = SPACE_BYTES / 2;
  localparam int OFS_LSB = 2;
  localparam int OFS_W = 8;
  localparam logic [7:0] FLAG_OFS = 8'hf7;
  localparam int BANK_BIT = 4;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  // mixed registers: upper nibble plain control, lower nibble sticky status
  localparam logic [7:0] MIXED_RW_MASK = 8'hf0;
  localparam logic [7:0] MIXED_STATUS_MASK = 8'h0f;
  localparam int MIXED_COUNT = 9;
  localparam int STATUS_W = 4;
  localparam logic [7:0] MIXED_OFS [MIXED_COUNT] = '{
    8'h20, 8'h23, 8'h24, 8'h27, 8'h28, 8'h64, 8'h65, 8'hd7, 8'hd9
  };

  // read-to-clear registers loaded by hardware
  localparam int RC_COUNT = 3;
  localparam logic [7:0] RC_OFS [RC_COUNT] = '{8'he2, 8'he4, 8'he5};

  localparam logic [7:0] WATCHDOG_CLEAR_OFS = 8'he3;

  typedef enum logic [2:0] {
    ACC_NONE = 3'h0,
    ACC_RW = 3'h1,
    ACC_WO = 3'h2,
    ACC_RC = 3'h3,
    ACC_MIXED = 3'h4
  } access_type;

  // bank 0 user map
  function automatic access_type bank0_access(input logic [7:0] ofs);
    access_type a;
    a = ACC_NONE;
    unique case (ofs) inside
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08: a = ACC_RW;
      [8'h09:8'h1f], [8'h80:8'h9f], [8'hc0:8'hc6], [8'hc8:8'hce]: a = ACC_RW;
      // 40-5f: blocks of four, data0 and control bit specific, data1 write only
      // limitation: these status nibbles have no hardware setter, only the write-one clear
      8'b010?_??10: a = ACC_RW;
      8'b010?_??01: a = ACC_WO;
      8'b010?_??00, 8'b010?_??11: a = ACC_MIXED;
      8'h22, 8'h26, 8'h60, 8'h63, 8'h66: a = ACC_RW;
      8'hd0, 8'hd1, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd8: a = ACC_RW;
      8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf, 8'he0, 8'he1: a = ACC_RW;
      8'he6, 8'he7: a = ACC_RW;
      8'h21, 8'h25, 8'ha8, 8'he3, 8'he8: a = ACC_WO;
      8'he2, 8'he4, 8'he5: a = ACC_RC;
      8'h20, 8'h23, 8'h24, 8'h27, 8'h28, 8'h64, 8'h65, 8'hd7, 8'hd9: a = ACC_MIXED;
      default: a = ACC_NONE;
    endcase
    return a;
  endfunction : bank0_access

endpackage : io_space_pkg

// ---- logic/io_space.sv ----
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ns
module io_space (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic EXTERNAL_RESET_PIN,
  input wire io_space_pkg::wb_req_type WB_REQ,
  output io_space_pkg::wb_rsp_type WB_RSP,
  input wire logic [io_space_pkg::MIXED_COUNT*io_space_pkg::STATUS_W-1:0] STATUS_EVENTS,
  input wire logic [io_space_pkg::RC_COUNT-1:0] RC_LOAD,
  input wire logic [io_space_pkg::RC_COUNT*8-1:0] RC_DATA,
  output logic BANK_SELECT,
  output logic WATCHDOG_CLEAR,
  output logic RESERVED_ACCESS
);

  // ****************************************************************
  // reset: pin or RESETN asserts at once, release is synchronised
  // ****************************************************************
  logic async_rst_n;
  logic rst_meta_reg;
  logic rst_sync_reg;

  assign async_rst_n = RESETN & ~EXTERNAL_RESET_PIN;

  always_ff @(posedge CLOCK or negedge async_rst_n) begin
    if (!async_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [io_space_pkg::BANK_BYTES-1:0][7:0] user_bank;
    logic [io_space_pkg::BANK_BYTES-1:0][7:0] config_bank;
    logic [7:0] flag;
    logic ack;
    logic [io_space_pkg::DAT_W-1:0] rdata;
    logic wdt_clear;
    logic reserved_hit;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic hit;
  logic wr;
  logic unmapped;
  logic [7:0] ofs;
  logic [7:0] wbyte;
  logic [7:0] old;
  io_space_pkg::access_type acc;

  always_comb begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.wdt_clear = 1'b0;
    state_next.reserved_hit = 1'b0;
    // one wait state, ack drops the cycle after it was given
    hit = WB_REQ.cyc & WB_REQ.stb & ~state_reg.ack;
    wr = hit & WB_REQ.we & WB_REQ.sel[0];
    ofs = WB_REQ.adr[io_space_pkg::OFS_LSB +: io_space_pkg::OFS_W];
    // anything above the 256-word window lies outside the space
    unmapped = |WB_REQ.adr[io_space_pkg::ADR_W-1:io_space_pkg::OFS_LSB+io_space_pkg::OFS_W];
    wbyte = WB_REQ.dat[7:0];
    acc = io_space_pkg::bank0_access(ofs);
    old = state_reg.user_bank[ofs];

    if (hit) begin
      state_next.ack = 1'b1;
      state_next.rdata = '0;
      if (unmapped) begin
        state_next.reserved_hit = 1'b1;
      end else if (ofs == io_space_pkg::FLAG_OFS) begin
        // flag register answers in both banks so the bank can be left again
        state_next.rdata[7:0] = state_reg.flag;
        if (wr) begin
          state_next.flag = wbyte;
        end
      end else if (state_reg.flag[io_space_pkg::BANK_BIT]) begin
        state_next.rdata[7:0] = state_reg.config_bank[ofs];
        if (wr) begin
          state_next.config_bank[ofs] = wbyte;
        end
      end else begin
        unique case (acc)
          io_space_pkg::ACC_RW: begin
            state_next.rdata[7:0] = old;
            if (wr) begin
              state_next.user_bank[ofs] = wbyte;
            end
          end
          io_space_pkg::ACC_WO: begin
            if (wr) begin
              state_next.user_bank[ofs] = wbyte;
              state_next.wdt_clear = (ofs == io_space_pkg::WATCHDOG_CLEAR_OFS);
            end
          end
          io_space_pkg::ACC_RC: begin
            state_next.rdata[7:0] = old;
            if (!WB_REQ.we) begin
              state_next.user_bank[ofs] = '0;
            end else if (wr) begin
              state_next.user_bank[ofs] = wbyte;
            end
          end
          io_space_pkg::ACC_MIXED: begin
            state_next.rdata[7:0] = old;
            if (wr) begin
              // control bits take the data, status bits clear where a one is written
              state_next.user_bank[ofs] = (wbyte & io_space_pkg::MIXED_RW_MASK) |
                (old & io_space_pkg::MIXED_STATUS_MASK & ~wbyte);
            end
          end
          io_space_pkg::ACC_NONE: begin
            // reserved: reads zero, writes dropped, flagged for debug
            state_next.reserved_hit = 1'b1;
          end
        endcase
      end
    end

    // hardware sets come last so an event beats a same-cycle clear
    for (int i = 0; i < io_space_pkg::MIXED_COUNT; i++) begin
      state_next.user_bank[io_space_pkg::MIXED_OFS[i]][io_space_pkg::STATUS_W-1:0] =
        state_next.user_bank[io_space_pkg::MIXED_OFS[i]][io_space_pkg::STATUS_W-1:0] |
        STATUS_EVENTS[i*io_space_pkg::STATUS_W +: io_space_pkg::STATUS_W];
    end
    for (int j = 0; j < io_space_pkg::RC_COUNT; j++) begin
      if (RC_LOAD[j]) begin
        state_next.user_bank[io_space_pkg::RC_OFS[j]] = RC_DATA[j*8 +: 8];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg.user_bank <= '0;
      state_reg.config_bank <= '0;
      state_reg.flag <= io_space_pkg::FLAG_RESET;
      state_reg.ack <= 1'b0;
      state_reg.rdata <= '0;
      state_reg.wdt_clear <= 1'b0;
      state_reg.reserved_hit <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs, all straight from state flops
  // ****************************************************************
  assign WB_RSP.ack = state_reg.ack;
  assign WB_RSP.dat = state_reg.rdata;
  assign BANK_SELECT = state_reg.flag[io_space_pkg::BANK_BIT];
  assign WATCHDOG_CLEAR = state_reg.wdt_clear;
  assign RESERVED_ACCESS = state_reg.reserved_hit;

endmodule : io_space

// ---- verif/io_space_assertions.sv ----
`timescale 1ns/1ns
module io_space_assertions (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic EXTERNAL_RESET_PIN,
  input wire io_space_pkg::wb_req_type WB_REQ,
  input wire io_space_pkg::wb_rsp_type WB_RSP,
  input wire logic BANK_SELECT,
  input wire logic WATCHDOG_CLEAR,
  input wire logic RESERVED_ACCESS
);
  // ****************************************************************
  // port relations
  // ****************************************************************
  wire take = WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
  wire wr = take && WB_REQ.we && WB_REQ.sel[0];
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN || EXTERNAL_RESET_PIN);
  property p_ack; take |=> WB_RSP.ack ##1 !WB_RSP.ack; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_hi; WB_RSP.ack |-> WB_RSP.dat[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_sel; wr && WB_REQ.adr[11:2] == 10'h0f7 |=> BANK_SELECT == $past(WB_REQ.dat[4]); endproperty
  a_sel: assert property (p_sel) else $error("bank select not from flag");
  property p_hold; !(wr && WB_REQ.adr[11:2] == 10'h0f7) |=> $stable(BANK_SELECT); endproperty
  a_hold: assert property (p_hold) else $error("bank select moved");
  property p_wdt; WATCHDOG_CLEAR == $past(wr && WB_REQ.adr[11:2] == 10'h0e3 && !BANK_SELECT); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
  property p_rsv; RESERVED_ACCESS |-> WB_RSP.ack && (WB_REQ.we || WB_RSP.dat == 32'h0); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved access wrong");
  // the pin itself must clear state, so only the other reset masks this
  property p_rst; disable iff (!RESETN) EXTERNAL_RESET_PIN |-> !BANK_SELECT && !WB_RSP.ack; endproperty
  a_rst: assert property (p_rst) else $error("pin reset ignored");
  c_bank: cover property ($rose(BANK_SELECT));
  c_wdt: cover property (WATCHDOG_CLEAR);
  c_rsv: cover property (RESERVED_ACCESS);
endmodule : io_space_assertions
bind io_space io_space_assertions u_chk (.CLOCK, .RESETN, .EXTERNAL_RESET_PIN, .WB_REQ, .WB_RSP, .BANK_SELECT,
  .WATCHDOG_CLEAR, .RESERVED_ACCESS);

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic EXTERNAL_RESET_PIN = 1'b0;
  io_space_pkg::wb_req_type WB_REQ = '0;
  io_space_pkg::wb_rsp_type WB_RSP;
  logic [35:0] STATUS_EVENTS = '0;
  logic [2:0] RC_LOAD = '0;
  logic [23:0] RC_DATA = '0;
  logic BANK_SELECT, WATCHDOG_CLEAR, RESERVED_ACCESS;
  logic [31:0] expq[$];
  logic [1:0] flagq[$];
  logic bank = 1'b0;
  logic [7:0] ofs [4] = '{8'h00, 8'h63, 8'hd6, 8'he1};
  logic [7:0] r;
  int num_errors = 0;
  int comparisons = 0;
  always #5 CLOCK = ~CLOCK;
  io_space dut (.CLOCK, .RESETN, .EXTERNAL_RESET_PIN, .WB_REQ, .WB_RSP, .STATUS_EVENTS, .RC_LOAD, .RC_DATA,
    .BANK_SELECT, .WATCHDOG_CLEAR, .RESERVED_ACCESS);
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // offsets with a register in the user bank map; all others must stay untouched
  function automatic logic rsv_ofs(input logic [7:0] o);
    return !(o <= 8'h28 || (o >= 8'h40 && o <= 8'h60) || (o >= 8'h63 && o <= 8'h66) ||
      (o >= 8'h80 && o <= 8'h9f) || o == 8'ha8 || (o >= 8'hc0 && o <= 8'hce && o != 8'hc7) ||
      o == 8'hd0 || o == 8'hd1 || (o >= 8'hd3 && o <= 8'he8) || o == 8'hf7);
  endfunction : rsv_ofs
  task automatic close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic wb(input logic w, input logic [7:0] o, input logic [7:0] d, input logic [1:0] hi = 2'b00);
    flagq.push_back({w && hi == 2'b00 && o == io_space_pkg::WATCHDOG_CLEAR_OFS && !bank, hi != 2'b00});
    if (w && hi == 2'b00 && o == io_space_pkg::FLAG_OFS)
      bank = d[io_space_pkg::BANK_BIT];
    WB_REQ <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {hi, o, 2'b00}, sel: 4'hf, dat: {24'h0, d}};
    do @(posedge CLOCK); while (WB_RSP.ack !== 1'b1);
    WB_REQ <= '0;
    @(posedge CLOCK);
  endtask : wb
  task automatic rd(input logic [7:0] o, input logic [31:0] e, input logic [1:0] hi = 2'b00);
    expq.push_back(e);
    wb(1'b0, o, 8'h00, hi);
  endtask : rd
  always @(posedge CLOCK)
    if (WB_RSP.ack === 1'b1) begin
      if (WB_REQ.we === 1'b0)
        chk("rd", expq.pop_front(), WB_RSP.dat);
      chk("flags", {30'h0, flagq.pop_front()}, {30'h0, WATCHDOG_CLEAR, RESERVED_ACCESS});
    end
  initial begin
    #50000;
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'h6e2906fc));
    repeat (2) @(posedge CLOCK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    for (int i = 0; i < 256; i++)
      if (!rsv_ofs(i[7:0]))
        rd(i[7:0], 32'h0);
    foreach (ofs[i]) begin
      r = 8'($urandom);
      wb(1'b1, ofs[i], r);
      rd(ofs[i], {24'h0, r});
    end
    wb(1'b1, 8'h21, 8'h5a);
    rd(8'h21, 32'h0);
    wb(1'b1, 8'h61, 8'h5a, 2'b01);
    rd(8'h61, 32'h0, 2'b01);
    wb(1'b1, 8'hf7, 8'h10);
    chk("bank", 32'h1, {31'h0, BANK_SELECT});
    wb(1'b1, 8'he1, 8'hc3);
    wb(1'b1, 8'he3, 8'h00);
    rd(8'he1, 32'hc3);
    wb(1'b1, 8'hf7, 8'h00);
    rd(8'he1, {24'h0, r});
    wb(1'b1, 8'he3, 8'h00);
    wb(1'b1, 8'h20, 8'hff);
    STATUS_EVENTS <= 36'h5;
    @(posedge CLOCK);
    STATUS_EVENTS <= '0;
    rd(8'h20, 32'hf5);
    wb(1'b1, 8'h20, 8'ha1);
    rd(8'h20, 32'ha4);
    STATUS_EVENTS <= 36'h4;
    wb(1'b1, 8'h20, 8'h04);
    STATUS_EVENTS <= '0;
    rd(8'h20, 32'h04);
    r = 8'($urandom);
    RC_DATA <= {8'h0, r, 8'h0};
    RC_LOAD <= 3'b010;
    @(posedge CLOCK);
    RC_LOAD <= '0;
    rd(8'he4, {24'h0, r});
    rd(8'he4, 32'h0);
    wb(1'b1, 8'hf7, 8'h10);
    EXTERNAL_RESET_PIN <= 1'b1;
    bank = 1'b0;
    repeat (2) @(posedge CLOCK);
    chk("bank", 32'h0, {31'h0, BANK_SELECT});
    EXTERNAL_RESET_PIN <= 1'b0;
    repeat (3) @(posedge CLOCK);
    rd(8'he1, 32'h0);
    @(posedge CLOCK);
    close_out();
  end
endmodule : testbench
